/* pkg/mbl_pkg.sv */
// Shared constants and types for the microsecond bus link master
package mbl_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DW_DIV = 8;
   localparam int unsigned DIV_W = $clog2(DW_DIV);
   localparam int unsigned FRAME_BITS = 16;
   localparam int unsigned CNT_W = $clog2(FRAME_BITS + 1);
   localparam int unsigned GAP_BITS = 16;
   localparam int unsigned GAP_W = $clog2(GAP_BITS);
   localparam int unsigned CONT_BITS = 512;
   localparam int unsigned WIN_W = $clog2(CONT_BITS);
   localparam int unsigned UP_RATIO = 64;
   localparam int unsigned UP_BIT_CYC = DW_DIV * UP_RATIO;
   localparam int unsigned UPC_W = $clog2(UP_BIT_CYC);
   localparam int unsigned UP_DATA_BITS = 8;
   localparam int unsigned UP_STOP_BITS = 3;
   localparam int unsigned UP_TMO_BITS = 25;
   localparam int unsigned UP_TMO_CYC = UP_TMO_BITS * UP_BIT_CYC;
   localparam logic [31:0] ST_CONFIG = 32'h00000001;
   localparam logic [31:0] ST_ACTIVE = 32'h00000002;
   localparam logic [ADDR_W-1:0] OFS_STATE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_TXEN = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_UPCTL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CMD = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_DATA0 = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_TRIG = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_UDR = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h1C;
   localparam int unsigned TRIG_CMD = 0;
   localparam int unsigned TRIG_DAT = 1;
   localparam int unsigned UDR_NEW = 8;
   localparam int unsigned FLG_TMO = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic diff_clock_positive;
      logic diff_clock_negative;
      logic diff_serial_out_positive;
      logic diff_serial_out_negative;
      logic chip_select_line_zero_n;
   } mbl_dw_pins_t;
   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_GAP} mbl_tx_st_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mbl_rx_st_t;
endpackage : mbl_pkg

/* design/mbl_link_master.sv */
// Microsecond bus link master with AXI4-Lite register slave
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
module mbl_link_master #(
   parameter int unsigned TMO_CYC = mbl_pkg::UP_TMO_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [mbl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [mbl_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic upstream_serial_input_zero,
   output mbl_pkg::mbl_dw_pins_t dw_pins
);
   import mbl_pkg::*;

   localparam int unsigned TMO_W = $clog2(TMO_CYC + 1);

   logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r, wmask, wval, rdata_r, rd_val, st_nxt;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic wr_en, rd_en, active;
   logic [31:0] state_r;
   logic txen_r, upen_r, pend_cmd_r, pend_dat_r;
   logic [FRAME_BITS-1:0] cmd_r, data0_r, sh_r;
   logic [9:0] udr_r;
   logic [3:0] flags_r;
   logic [DIV_W-1:0] div_r, div_nxt;
   logic bit_tick, start, tx_done, clk_r, so_r, cs_n_r, tx_is_cmd_r;
   mbl_tx_st_t tx_st_r;
   logic [CNT_W-1:0] bit_cnt_r;
   logic [GAP_W-1:0] gap_r;
   logic [WIN_W-1:0] win_r;
   logic si_s1_r, si_s2_r, si_s3_r;
   mbl_rx_st_t rx_st_r;
   logic [UPC_W-1:0] rx_cnt_r;
   logic [1:0] rx_bits_r;
   logic [2:0] rx_dbit_r;
   logic [UP_DATA_BITS-1:0] rx_sh_r;
   logic rx_serr_r, rx_done, rx_serr, tmo_on_r, tmo_hit;
   logic [TMO_W-1:0] tmo_cnt_r;

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return a == OFS_STATE || a == OFS_TXEN || a == OFS_UPCTL ||
             a == OFS_CMD || a == OFS_DATA0 || a == OFS_TRIG ||
             a == OFS_UDR || a == OFS_FLAGS;
   endfunction : mapped

   // Bus slave: address and data are taken in either order
   for (genvar b = 0; b < 4; b++) begin : g_mask
      assign wmask[8*b +: 8] = {8{wstrb_r[b]}};
   end
   assign wval = wdata_r & wmask;
   assign s_axi_awready = !aw_got_r && !bvalid_r;
   assign s_axi_wready = !w_got_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign wr_en = aw_got_r && w_got_r && !bvalid_r;
   assign rd_en = s_axi_arvalid && !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         awaddr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_got_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end else if (wr_en) begin
         aw_got_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_got_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end else if (wr_en) begin
         w_got_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_en) begin
         bvalid_r <= 1'b1;
         bresp_r <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   always_comb begin
      case (s_axi_araddr)
         OFS_STATE: rd_val = state_r;
         OFS_TXEN: rd_val = 32'(txen_r);
         OFS_UPCTL: rd_val = 32'(upen_r);
         OFS_CMD: rd_val = 32'(cmd_r);
         OFS_DATA0: rd_val = 32'(data0_r);
         OFS_TRIG: rd_val = 32'({pend_dat_r, pend_cmd_r});
         OFS_UDR: rd_val = 32'(udr_r);
         OFS_FLAGS: rd_val = 32'({tx_st_r != TX_IDLE, flags_r});
         default: rd_val = '0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (rd_en) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_val;
         rresp_r <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Only the two legal state codes are accepted
   assign st_nxt = (state_r & ~wmask) | wval;
   assign active = state_r == ST_ACTIVE;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_CONFIG;
      end else if (wr_en && awaddr_r == OFS_STATE &&
                   (st_nxt == ST_CONFIG || st_nxt == ST_ACTIVE)) begin
         state_r <= st_nxt;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txen_r <= 1'b0;
         upen_r <= 1'b0;
      end else if (wr_en && wstrb_r[0]) begin
         if (awaddr_r == OFS_TXEN) begin
            txen_r <= wdata_r[0];
         end
         // Upstream setup only changes while configuring
         if (awaddr_r == OFS_UPCTL && state_r == ST_CONFIG) begin
            upen_r <= wdata_r[0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_r <= '0;
         data0_r <= '0;
      end else if (wr_en && awaddr_r == OFS_CMD) begin
         cmd_r <= (cmd_r & ~wmask[15:0]) | wval[15:0];
      end else if (wr_en && awaddr_r == OFS_DATA0) begin
         data0_r <= (data0_r & ~wmask[15:0]) | wval[15:0];
      end
   end

   // A trigger posted while the frame starts is kept, not lost
   always_ff @(posedge aclk) begin
      if (!aresetn || !active) begin
         pend_cmd_r <= 1'b0;
         pend_dat_r <= 1'b0;
      end else begin
         pend_cmd_r <= (pend_cmd_r && !(start && pend_cmd_r)) ||
                       (wr_en && awaddr_r == OFS_TRIG && wval[TRIG_CMD]);
         pend_dat_r <= (pend_dat_r && !(start && !pend_cmd_r)) ||
                       (wr_en && awaddr_r == OFS_TRIG && wval[TRIG_DAT]);
      end
   end

   // Bit clock; held low outside the active state
   assign bit_tick = active && div_r == DIV_W'(DW_DIV - 1);
   assign div_nxt = bit_tick ? '0 : div_r + 1'b1;
   always_ff @(posedge aclk) begin
      if (!aresetn || !active) begin
         // One count short so the first clock high phase is a full one
         div_r <= DIV_W'(DW_DIV - 1);
         clk_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         clk_r <= div_nxt < DIV_W'(DW_DIV / 2);
      end
   end

   assign start = bit_tick && tx_st_r == TX_IDLE && txen_r && win_r == '0 &&
                  (pend_cmd_r || pend_dat_r);
   assign tx_done = bit_tick && tx_st_r == TX_SHIFT && bit_cnt_r == '0;

   always_ff @(posedge aclk) begin
      if (!aresetn || !active) begin
         win_r <= '0;
      end else if (start) begin
         win_r <= WIN_W'(CONT_BITS - 1);
      end else if (bit_tick && win_r != '0) begin
         win_r <= win_r - 1'b1;
      end
   end

   // Outputs change with the tick edge, which is the clock's rising edge
   always_ff @(posedge aclk) begin
      if (!aresetn || !active) begin
         tx_st_r <= TX_IDLE;
         bit_cnt_r <= '0;
         sh_r <= '0;
         so_r <= 1'b0;
         cs_n_r <= 1'b1;
         gap_r <= '0;
         tx_is_cmd_r <= 1'b0;
      end else if (bit_tick) begin
         case (tx_st_r)
            TX_IDLE: begin
               if (start) begin
                  tx_st_r <= TX_SHIFT;
                  tx_is_cmd_r <= pend_cmd_r;
                  so_r <= pend_cmd_r;
                  sh_r <= pend_cmd_r ? cmd_r : data0_r;
                  bit_cnt_r <= CNT_W'(FRAME_BITS);
                  cs_n_r <= 1'b0;
               end
            end
            TX_SHIFT: begin
               if (bit_cnt_r == '0) begin
                  tx_st_r <= TX_GAP;
                  cs_n_r <= 1'b1;
                  so_r <= 1'b0;
                  // End bit counts as the first idle bit
                  gap_r <= GAP_W'(GAP_BITS - 2);
               end else begin
                  so_r <= sh_r[FRAME_BITS-1];
                  sh_r <= {sh_r[FRAME_BITS-2:0], 1'b0};
                  bit_cnt_r <= bit_cnt_r - 1'b1;
               end
            end
            TX_GAP: begin
               if (gap_r == '0) begin
                  tx_st_r <= TX_IDLE;
               end else begin
                  gap_r <= gap_r - 1'b1;
               end
            end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   assign dw_pins.diff_clock_positive = clk_r;
   assign dw_pins.diff_clock_negative = !clk_r;
   assign dw_pins.diff_serial_out_positive = so_r;
   assign dw_pins.diff_serial_out_negative = !so_r;
   assign dw_pins.chip_select_line_zero_n = cs_n_r;

   // Reply line is asynchronous, hence the synchroniser
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         si_s1_r <= 1'b1;
         si_s2_r <= 1'b1;
         si_s3_r <= 1'b1;
      end else begin
         si_s1_r <= upstream_serial_input_zero;
         si_s2_r <= si_s1_r;
         si_s3_r <= si_s2_r;
      end
   end

   assign rx_done = rx_st_r == RX_STOP && rx_cnt_r == '0 &&
                    rx_bits_r == 2'(UP_STOP_BITS - 1);
   assign rx_serr = rx_serr_r || !si_s2_r;

   always_ff @(posedge aclk) begin
      if (!aresetn || !upen_r || !active) begin
         rx_st_r <= RX_IDLE;
         rx_cnt_r <= '0;
         rx_bits_r <= '0;
         rx_dbit_r <= '0;
         rx_sh_r <= '0;
         rx_serr_r <= 1'b0;
      end else if (rx_cnt_r != '0) begin
         rx_cnt_r <= rx_cnt_r - 1'b1;
      end else begin
         case (rx_st_r)
            RX_IDLE: begin
               if (si_s3_r && !si_s2_r) begin
                  rx_st_r <= RX_START;
                  rx_cnt_r <= UPC_W'(UP_BIT_CYC / 2 - 1);
               end
            end
            RX_START: begin
               // A start bit that is gone at mid-bit was a glitch
               rx_st_r <= si_s2_r ? RX_IDLE : RX_DATA;
               rx_cnt_r <= si_s2_r ? '0 : UPC_W'(UP_BIT_CYC - 1);
               rx_dbit_r <= '0;
               rx_serr_r <= 1'b0;
            end
            RX_DATA: begin
               rx_sh_r <= {si_s2_r, rx_sh_r[UP_DATA_BITS-1:1]};
               rx_cnt_r <= UPC_W'(UP_BIT_CYC - 1);
               rx_dbit_r <= rx_dbit_r + 1'b1;
               if (rx_dbit_r == 3'(UP_DATA_BITS - 1)) begin
                  rx_st_r <= RX_STOP;
                  rx_bits_r <= '0;
               end
            end
            RX_STOP: begin
               rx_serr_r <= rx_serr;
               if (rx_done) begin
                  rx_st_r <= RX_IDLE;
               end else begin
                  rx_bits_r <= rx_bits_r + 1'b1;
                  rx_cnt_r <= UPC_W'(UP_BIT_CYC - 1);
               end
            end
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end

   // Armed by each sent command; a reply disarms it
   assign tmo_hit = tmo_on_r && tmo_cnt_r == '0 && !rx_done;
   always_ff @(posedge aclk) begin
      if (!aresetn || !upen_r) begin
         tmo_on_r <= 1'b0;
         tmo_cnt_r <= '0;
      end else if (tx_done && tx_is_cmd_r) begin
         tmo_on_r <= 1'b1;
         tmo_cnt_r <= TMO_W'(TMO_CYC - 1);
      end else if (rx_done || tmo_hit) begin
         tmo_on_r <= 1'b0;
      end else if (tmo_on_r) begin
         tmo_cnt_r <= tmo_cnt_r - 1'b1;
      end
   end

   // A new reply overrides the read-clear of the fresh bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         udr_r <= '0;
      end else if (rx_done) begin
         udr_r <= {rx_serr, 1'b1, rx_sh_r};
      end else if (rd_en && s_axi_araddr == OFS_UDR) begin
         udr_r[UDR_NEW] <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_r <= '0;
      end else begin
         flags_r <= (flags_r & ~((wr_en && awaddr_r == OFS_FLAGS) ?
                     wval[3:0] : 4'h0)) |
                    {rx_done && rx_serr, tmo_hit, rx_done, tx_done};
      end
   end

   // Helpers counting bit periods since the last frame start and end
   logic [9:0] since_start_h;
   logic [4:0] since_end_h;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         since_start_h <= '1;
         since_end_h <= '1;
      end else begin
         if (start) begin
            since_start_h <= 10'h001;
         end else if (bit_tick && since_start_h != '1) begin
            since_start_h <= since_start_h + 1'b1;
         end
         if (tx_done) begin
            since_end_h <= 5'h01;
         end else if (bit_tick && since_end_h != '1) begin
            since_end_h <= since_end_h + 1'b1;
         end
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence frame_open;
      $fell(cs_n_r);
   endsequence
   sequence frame_body;
      ##135 !cs_n_r ##1 cs_n_r;
   endsequence

   tick_spacing_a: assert property (bit_tick |=> !bit_tick [*7])
      else $error("bit tick spacing is not eight clocks");
   frame_length_a: assert property (frame_open |-> frame_body)
      else $error("frame is not seventeen bit periods long");
   sel_bit_a: assert property (frame_open |-> so_r == tx_is_cmd_r)
      else $error("selection bit does not match frame kind");
   cs_active_a: assert property ((tx_st_r == TX_SHIFT) == !cs_n_r)
      else $error("chip select does not track the frame");
   idle_gap_a: assert property (start |-> since_end_h >= 5'(GAP_BITS))
      else $error("idle gap shorter than sixteen bits");
   cont_window_a: assert property (start |->
      since_start_h >= 10'(CONT_BITS))
      else $error("frame restarted inside the continuous window");
   tx_gate_a: assert property (frame_open |->
      $past(txen_r) && $past(active))
      else $error("frame sent without enable or outside active");
   data_edge_a: assert property (active && $changed(so_r) |->
      $rose(clk_r))
      else $error("data changed away from clock rise");
   clk_free_a: assert property ($rose(clk_r) |->
      ##8 ($rose(clk_r) || !active))
      else $error("downstream clock stopped while active");
   reply_store_a: assert property (rx_done |=>
      udr_r[UDR_NEW] && udr_r[7:0] == $past(rx_sh_r))
      else $error("received byte not stored");
   timeout_flag_a: assert property (tmo_hit |=> flags_r[FLG_TMO])
      else $error("timeout not flagged");
endmodule : mbl_link_master

/* bench/mbl_far_ic.sv */
// Behavioural far-side driver IC on the microsecond serial bus
`timescale 1ns/1ps
module mbl_far_ic #(
   parameter logic [15:0] WR_CMD = 16'h1541,
   parameter logic [15:0] RD_CMD = 16'h1010,
   parameter logic [7:0] WR_VAL = 8'hAA
) (
   input wire logic aclk,
   input mbl_pkg::mbl_dw_pins_t dw_pins,
   input wire logic [15:0] reply_dly,
   input wire logic bad_stop,
   output logic upstream_serial_input_zero
);
   import mbl_pkg::*;
   localparam realtime BIT_T = UP_BIT_CYC * 8.0;
   logic [16:0] frm;
   logic [7:0] reg_val;
   initial begin
      upstream_serial_input_zero = 1'b1;
      reg_val = 8'h00;
      forever begin
         @(negedge dw_pins.chip_select_line_zero_n);
         // Sample mid-bit, away from the rising edge where data moves
         repeat (17) begin
            @(negedge dw_pins.diff_clock_positive);
            frm = {frm[15:0], dw_pins.diff_serial_out_positive};
         end
         if (frm == {1'b1, WR_CMD}) reg_val = WR_VAL;
         if (frm == {1'b1, RD_CMD}) begin
            repeat (reply_dly) @(posedge aclk);
            #3.3; // Off the aclk grid, replies are unsynchronised
            upstream_serial_input_zero = 1'b0;
            #(BIT_T);
            for (int i = 0; i < 8; i++) begin
               upstream_serial_input_zero = reg_val[i];
               #(BIT_T);
            end
            upstream_serial_input_zero = !bad_stop;
            #(BIT_T);
            upstream_serial_input_zero = 1'b1;
            #(2 * BIT_T);
         end
      end
   end
endmodule : mbl_far_ic

/* bench/mbl_link_master_tb.sv */
// Self-checking bench for the microsecond bus link master
`timescale 1ns/1ps
module mbl_link_master_tb;
   import mbl_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, sin, bad_stop, act;
   logic cs_q, clk_q, so_q, run;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, m_n;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [15:0] reply_dly, rcmd;
   logic [16:0] sh;
   logic [33:0] e_n;
   mbl_dw_pins_t pins;
   int n_mismatch = 0, n_tests = 0, seed = 66974, cyc = 0, n_frames = 0;
   int t_end = 0, low = 0, gap = 9999, since = 9999, tcnt = 0;
   logic [33:0] exp_r[$];
   logic [31:0] msk_r[$];
   logic [1:0] exp_b[$];
   logic [16:0] exp_f[$];
   mbl_link_master u_mbl_link_master (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .upstream_serial_input_zero(sin),
      .dw_pins(pins));
   mbl_far_ic u_mbl_far_ic (.aclk(aclk), .dw_pins(pins),
      .reply_dly(reply_dly), .bad_stop(bad_stop),
      .upstream_serial_input_zero(sin));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   task automatic wait_until(input int c);
      while (cyc < c) @(posedge aclk);
   endtask : wait_until
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      exp_b.push_back(e);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && awready === 1'b1) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready === 1'b1) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] er,
                     input logic [31:0] e, input logic [31:0] m);
      exp_r.push_back({er, e});
      msk_r.push_back(m);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask : rd
   // Response watcher: oldest note against each answer
   always @(posedge aclk) begin
      if (bvalid === 1'b1 && bready === 1'b1) begin
         check(34'(bresp), 34'(exp_b.pop_front()));
      end
      if (rvalid === 1'b1 && rready === 1'b1) begin
         e_n = exp_r.pop_front();
         m_n = msk_r.pop_front();
         check({rresp, rdata & m_n}, {e_n[33:32], e_n[31:0] & m_n});
      end
   end
   // Pin watcher: frame content, framing, spacing and clock shape
   always @(posedge aclk) begin
      cyc++;
      if (aresetn === 1'b1) begin
         check(34'(pins.diff_clock_negative ^ pins.diff_clock_positive),
               34'd1);
         check(34'(pins.diff_serial_out_negative ^
               pins.diff_serial_out_positive), 34'd1);
         if (cs_q === 1'b1 && pins.chip_select_line_zero_n === 1'b0) begin
            check(34'(gap >= 128), 34'd1);
            check(34'(since >= 4096), 34'd1);
            low = 0;
            since = 0;
         end
         if (pins.chip_select_line_zero_n === 1'b0) begin
            if (low % 8 == 0) sh = {sh[15:0], pins.diff_serial_out_positive};
            low++;
         end
         if (cs_q === 1'b0 && pins.chip_select_line_zero_n === 1'b1) begin
            check(34'(low), 34'd136);
            check(34'(sh), 34'(exp_f.pop_front()));
            n_frames++;
            t_end = cyc;
            gap = 0;
         end
         if (pins.diff_serial_out_positive !== so_q) begin
            check(34'(pins.diff_clock_positive && !clk_q), 34'd1);
         end
         if (pins.diff_clock_positive !== clk_q) begin
            if (run) check(34'(tcnt), 34'd3);
            run = act;
            tcnt = 0;
         end else begin
            tcnt++;
         end
         gap++;
         since++;
      end
      cs_q = pins.chip_select_line_zero_n;
      clk_q = pins.diff_clock_positive;
      so_q = pins.diff_serial_out_positive;
   end
   initial begin
      // Longest path is about 50000 cycles of frames and replies
      repeat (80000) @(posedge aclk);
      n_mismatch++;
      end_sim();
   end
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, bad_stop} = 6'h00;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hF;
      reply_dly = 16'd7;
      {act, run, clk_q, so_q} = 4'h0;
      cs_q = 1'b1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_STATE, RESP_OKAY, ST_CONFIG, 32'hFFFFFFFF);
      rd(OFS_UDR, RESP_OKAY, 32'h0, 32'h3FF);
      rd(8'h20, RESP_SLVERR, 32'h0, 32'hFFFFFFFF);
      wr(8'h24, 32'h1, RESP_SLVERR);
      wr(OFS_UPCTL, 32'h1, RESP_OKAY);
      wr(OFS_CMD, 32'h1541, RESP_OKAY);
      rd(OFS_CMD, RESP_OKAY, 32'h1541, 32'hFFFF);
      wr(OFS_DATA0, 32'hF0F0, RESP_OKAY);
      wr(OFS_TRIG, 32'h1, RESP_OKAY);
      rd(OFS_TRIG, RESP_OKAY, 32'h0, 32'h3);
      wr(OFS_STATE, ST_ACTIVE, RESP_OKAY);
      act = 1'b1;
      wr(OFS_UPCTL, 32'h0, RESP_OKAY);
      rd(OFS_UPCTL, RESP_OKAY, 32'h1, 32'h1);
      exp_f.push_back({1'b1, 16'h1541});
      exp_f.push_back({1'b0, 16'hF0F0});
      wr(OFS_TRIG, 32'h3, RESP_OKAY);
      wait_until(cyc + 600);
      check(34'(n_frames), 34'd0);
      rd(OFS_TRIG, RESP_OKAY, 32'h3, 32'h3);
      wr(OFS_TXEN, 32'h1, RESP_OKAY);
      wait_until(cyc + 20000 * (n_frames < 2));
      check(34'(n_frames), 34'd2);
      wr(OFS_CMD, 32'h1010, RESP_OKAY);
      exp_f.push_back({1'b1, 16'h1010});
      wr(OFS_TRIG, 32'h1, RESP_OKAY);
      while (n_frames < 3) @(posedge aclk);
      // Reply is twelve bits of 512 cycles after the far side's delay
      wait_until(cyc + 7000);
      rd(OFS_UDR, RESP_OKAY, 32'h1AA, 32'h3FF);
      rd(OFS_UDR, RESP_OKAY, 32'h0AA, 32'h1FF);
      rd(OFS_FLAGS, RESP_OKAY, 32'h3, 32'h3);
      reply_dly <= 16'd300;
      bad_stop <= 1'b1;
      exp_f.push_back({1'b1, 16'h1010});
      wr(OFS_TRIG, 32'h1, RESP_OKAY);
      while (n_frames < 4) @(posedge aclk);
      wait_until(cyc + 7000);
      rd(OFS_UDR, RESP_OKAY, 32'h3AA, 32'h3FF);
      rd(OFS_FLAGS, RESP_OKAY, 32'h8, 32'h8);
      wr(OFS_FLAGS, 32'hF, RESP_OKAY);
      rd(OFS_FLAGS, RESP_OKAY, 32'h0, 32'hF);
      rcmd = {4'h2, 12'($random(seed))};
      wr(OFS_CMD, {16'h0, rcmd}, RESP_OKAY);
      exp_f.push_back({1'b1, rcmd});
      wr(OFS_TRIG, 32'h1, RESP_OKAY);
      while (n_frames < 5) @(posedge aclk);
      wait_until(t_end + UP_TMO_CYC - 30);
      rd(OFS_FLAGS, RESP_OKAY, 32'h0, 32'h4);
      wait_until(t_end + UP_TMO_CYC + 30);
      rd(OFS_FLAGS, RESP_OKAY, 32'h4, 32'h4);
      end_sim();
   end
endmodule : mbl_link_master_tb
